// *** design/addc_pkg.sv ***
// Shared constants, types and helpers for the dual acquisition downconverter channel.
package addc_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDC_CTRL      = 8'h00;
  localparam logic [7:0] ADDC_STATUS    = 8'h04;
  localparam logic [7:0] ADDC_TUNE0     = 8'h08;
  localparam logic [7:0] ADDC_TUNE1     = 8'h0C;
  localparam logic [7:0] ADDC_DECIM0    = 8'h10;
  localparam logic [7:0] ADDC_DECIM1    = 8'h14;
  localparam logic [7:0] ADDC_COEF_SEL  = 8'h18;
  localparam logic [7:0] ADDC_COEF_DATA = 8'h1C;
  localparam logic [7:0] ADDC_LINK_BASE = 8'h20;
  localparam logic [7:0] ADDC_TSTAMP    = 8'h40;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int          CTRL_RUN_LSB  = 0;
  localparam int          CTRL_META_LSB = 2;
  localparam int          CTRL_SEL_LSB  = 4;
  localparam int          CTRL_FMT_LSB  = 8;
  localparam int          LINK_GATE_BIT = 16;
  localparam int          LINK_LAST_BIT = 17;
  localparam int          LINK_NEXT_LSB = 18;
  localparam int          META_CHAN_LSB = 56;
  localparam int          META_LEN_LSB  = 32;
  localparam int          NLINKS        = 4;
  localparam int          NTAPS         = 16;
  localparam logic [16:0] DECIM_MIN     = 17'h00002;
  localparam logic [16:0] DECIM_MAX     = 17'h10000;
  localparam logic [16:0] DECIM_RST     = 17'h00002;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // Sixteen-point sine table over one period in Q15; cosine reads it four entries ahead.
  localparam logic [15:0] SIN_LUT [NTAPS] = '{
    16'h0000, 16'h30FB, 16'h5A82, 16'h7641, 16'h7FFF, 16'h7641, 16'h5A82, 16'h30FB,
    16'h0000, 16'hCF05, 16'hA57E, 16'h89BF, 16'h8001, 16'h89BF, 16'hA57E, 16'hCF05};

  // Default low-pass window, sized for an eighty percent output band.
  localparam logic [15:0] COEF_RST [NTAPS] = '{
    16'h0100, 16'h0400, 16'h0A00, 16'h1400, 16'h2000, 16'h2C00, 16'h3400, 16'h3800,
    16'h3800, 16'h3400, 16'h2C00, 16'h2000, 16'h1400, 16'h0A00, 16'h0400, 16'h0100};

  typedef enum logic [1:0] {
    SRC_ADC_A = 2'b00,
    SRC_ADC_B = 2'b01,
    SRC_TEST  = 2'b10
  } addc_src_t;

  typedef enum logic [2:0] {
    DMA_IDLE = 3'b000,
    DMA_LOAD = 3'b001,
    DMA_WAIT = 3'b010,
    DMA_XFER = 3'b011,
    DMA_META = 3'b100,
    DMA_NEXT = 3'b101
  } addc_dma_t;

  function automatic logic [16:0] addc_clamp(input logic [16:0] d);
    if (d < DECIM_MIN) begin
      return DECIM_MIN;
    end
    if (d > DECIM_MAX) begin
      return DECIM_MAX;
    end
    return d;
  endfunction

endpackage

// *** design/addc_ddc_if.sv ***
// Control and sample bundle between the channel top and one downconverter.
`timescale 1ns/1ns
interface addc_ddc_if;
  logic        start;
  logic [31:0] tune;
  logic [16:0] decim;
  logic        fmt16;
  logic        coef_we;
  logic [3:0]  coef_idx;
  logic [15:0] coef_data;
  logic [13:0] sample;
  logic        out_valid;
  logic [23:0] out_i;
  logic [23:0] out_q;

  modport ctl (output start, tune, decim, fmt16, coef_we, coef_idx, coef_data, sample,
               input out_valid, out_i, out_q);
  modport ddc (input start, tune, decim, fmt16, coef_we, coef_idx, coef_data, sample,
               output out_valid, out_i, out_q);
endinterface

// *** design/addc_ddc.sv ***
// One complex downconverter: phase accumulator, mixer and coefficient-weighted decimator.
`timescale 1ns/1ns
module addc_ddc
  import addc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  addc_ddc_if.ddc  bus
);

  typedef struct packed {
    logic [31:0]               tune;
    logic [31:0]               phase;
    logic [15:0]               dm1;
    logic [15:0]               cnt;
    logic [3:0]                tap;
    logic                      fmt16;
    logic                      run;
    logic signed [47:0]        acc_i;
    logic signed [47:0]        acc_q;
    logic [NTAPS-1:0][15:0]    coef;
    logic                      ov;
    logic [23:0]               oi;
    logic [23:0]               oq;
  } addc_ddc_st_t;

  addc_ddc_st_t r;
  addc_ddc_st_t next_r;

  assign bus.out_valid = r.ov;
  assign bus.out_i     = r.oi;
  assign bus.out_q     = r.oq;

  // ****************************************
  // Datapath
  // ****************************************
  always_comb begin
    logic signed [29:0] mi;
    logic signed [29:0] mq;
    logic signed [31:0] ti;
    logic signed [31:0] tq;
    logic signed [47:0] si;
    logic signed [47:0] sq;
    logic [3:0]         ph;
    logic [16:0]        dcl;
    mi = '0;
    mq = '0;
    ti = '0;
    tq = '0;
    ph = r.phase[31:28];
    dcl = addc_clamp(bus.decim);
    next_r = r;
    next_r.ov = 1'b0;
    // The mixer uses a coarse sixteen-point table to keep the slice count low.
    mi = $signed(bus.sample) * $signed(SIN_LUT[4'(ph + 4'h4)]);
    mq = -($signed(bus.sample) * $signed(SIN_LUT[ph]));
    ti = $signed(mi[29:14]) * $signed(r.coef[r.tap]);
    tq = $signed(mq[29:14]) * $signed(r.coef[r.tap]);
    si = r.acc_i + 48'(ti);
    sq = r.acc_q + 48'(tq);
    if (bus.coef_we) begin
      next_r.coef[bus.coef_idx] = bus.coef_data;
    end
    if (bus.start) begin
      next_r.tune  = bus.tune;
      next_r.dm1   = 16'(dcl - 17'h00001);
      next_r.fmt16 = bus.fmt16;
      next_r.phase = '0;
      next_r.cnt   = '0;
      next_r.tap   = '0;
      next_r.acc_i = '0;
      next_r.acc_q = '0;
      next_r.run   = 1'b1;
    end else if (r.run) begin
      next_r.phase = r.phase + r.tune;
      if (r.cnt == r.dm1) begin
        next_r.ov = 1'b1;
        next_r.oi = r.fmt16 ? {{8{si[47]}}, si[47:32]} : si[47:24];
        next_r.oq = r.fmt16 ? {{8{sq[47]}}, sq[47:32]} : sq[47:24];
        next_r.acc_i = '0;
        next_r.acc_q = '0;
        next_r.cnt = '0;
        next_r.tap = '0;
      end else begin
        next_r.acc_i = si;
        next_r.acc_q = sq;
        next_r.cnt = r.cnt + 16'h0001;
        next_r.tap = r.tap + 4'h1;
      end
    end
    if (!aresetn) begin
      next_r = '0;
      for (int k = 0; k < NTAPS; k++) begin
        next_r.coef[k] = COEF_RST[k];
      end
    end
  end

  always_ff @(posedge aclk) begin
    r <= next_r;
  end

  // ****************************************
  // Checks
  // ****************************************
  logic [16:0] gap;
  always_ff @(posedge aclk) begin
    // Restart the count on the edge that launches a strobe, so each period measures dm1.
    if (!aresetn || bus.start || next_r.ov) begin
      gap <= '0;
    end else begin
      gap <= gap + 17'h00001;
    end
  end

  chk_out_period: assert property (@(posedge aclk) disable iff (!aresetn)
    r.ov && $past(r.run) && !$past(bus.start) |-> $past(gap) == 17'(r.dm1))
    else $error("output strobe spacing differs from decimation factor");
  chk_strobe_single: assert property (@(posedge aclk) disable iff (!aresetn)
    r.ov |=> !r.ov)
    else $error("output strobe longer than one cycle");
  chk_decim_range: assert property (@(posedge aclk) disable iff (!aresetn)
    bus.start |=> r.dm1 >= 16'h0001 && 17'(r.dm1) == 17'(addc_clamp($past(bus.decim)) - 17'h1))
    else $error("decimation factor not latched within range");
  chk_coef_load: assert property (@(posedge aclk) disable iff (!aresetn)
    bus.coef_we |=> r.coef[$past(bus.coef_idx)] == $past(bus.coef_data))
    else $error("coefficient write lost");
  chk_tune_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    r.run && !bus.start |=> r.tune == $past(r.tune) && r.phase == $past(r.phase) + $past(r.tune))
    else $error("tuning word changed outside a restart");

endmodule

// *** design/addc_top.sv ***
// Two acquisition channels: source selection, downconversion and linked-list DMA.
//
// Local design decisions: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns

// Operation
// - Channel 0 picks its input from converter A, converter B or the test source; channel 1 always takes converter A.
// - One converter may feed both downconverters, or each converter its own.
// - Each channel has its own DMA engine driving its own output stream.
// - The DMA walks a list of link words, one transfer per link, then follows the next index.
// - A gate-driven link transfers the samples taken while the gate is high, from the cycle after its rise is seen.
// - With metadata on, each transfer ends with a beat holding channel id, length and timestamp.
// - Each downconverter has its own 32-bit tuning word covering zero up to the sample rate.
// - Each downconverter has its own decimation factor from 2 to 65536.
// - Each downconverter loads its own set of 16-bit filter coefficients.
// - The coefficients after reset form a low-pass window for an eighty percent band.
// - Complex output comes once per decimation period as 24+24 or 16+16 bit samples.
// - Gate, trigger and sync come from the timing generator and steer acquisition.
module addc_top
  import addc_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [13:0]       adc_a,
  input  wire logic [13:0]       adc_b,
  input  wire logic              gate_in,
  input  wire logic              trig_in,
  input  wire logic              sync_in,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [1:0]             dma_valid,
  output logic [1:0]             dma_meta,
  output logic [1:0][63:0]       dma_data
);

  typedef struct packed {
    addc_dma_t   state;
    logic [1:0]  link;
    logic [15:0] len;
    logic        gate;
    logic        last;
    logic [1:0]  nxt;
    logic [23:0] cnt;
    logic [31:0] ts;
    logic        ov;
    logic        om;
    logic [63:0] od;
  } addc_chan_t;

  typedef struct packed {
    logic [13:0]                  a1, a2, b1, b2;
    logic                         g1, g2, gp, t1, t2, tp, s1, s2, sp;
    logic [13:0]                  test;
    logic [31:0]                  tstamp;
    logic [31:0]                  ctrl;
    logic [1:0]                   run_q;
    logic [1:0][31:0]             tune;
    logic [1:0][16:0]             decim;
    logic [4:0]                   coef_sel;
    logic [1:0]                   coef_we;
    logic [15:0]                  coef_data;
    logic [1:0]                   start;
    logic [1:0][NLINKS-1:0][19:0] links;
    addc_chan_t [1:0]             ch;
    logic                         aw_have, w_have, awready, wready, bvalid;
    logic [7:0]                   awaddr_q;
    logic [31:0]                  wdata_q;
    logic [3:0]                   wstrb_q;
    logic [1:0]                   bresp;
    logic                         arready, rvalid;
    logic [31:0]                  rdata;
    logic [1:0]                   rresp;
  } addc_top_t;

  addc_top_t r;
  addc_top_t next_r;

  logic [1:0]       ddc_ov;
  logic [1:0][23:0] ddc_i;
  logic [1:0][23:0] ddc_q;

  function automatic logic addc_mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= ADDC_TSTAMP);
  endfunction

  function automatic logic [31:0] addc_merge(input logic [31:0] o, input logic [31:0] d,
                                             input logic [3:0] s);
    logic [31:0] m;
    m = o;
    for (int k = 0; k < 4; k++) begin
      if (s[k]) begin
        m[8*k +: 8] = d[8*k +: 8];
      end
    end
    return m;
  endfunction

  // ****************************************
  // Downconverters and input routing
  // ****************************************
  addc_ddc_if ddc_bus [2] ();

  for (genvar c = 0; c < 2; c++) begin : g_chan
    logic [1:0] sel;
    assign sel = r.ctrl[CTRL_SEL_LSB + 2*c +: 2];
    // Both selectors see both converters, but the CTRL write mask clears bits 7:6, so only converter A may be shared.
    assign ddc_bus[c].sample = (sel == SRC_ADC_A) ? r.a2 :
                               (sel == SRC_ADC_B) ? r.b2 : r.test;
    assign ddc_bus[c].start     = r.start[c];
    assign ddc_bus[c].tune      = r.tune[c];
    assign ddc_bus[c].decim     = r.decim[c];
    assign ddc_bus[c].fmt16     = r.ctrl[CTRL_FMT_LSB + c];
    assign ddc_bus[c].coef_we   = r.coef_we[c];
    assign ddc_bus[c].coef_idx  = r.coef_sel[3:0];
    assign ddc_bus[c].coef_data = r.coef_data;
    assign ddc_ov[c] = ddc_bus[c].out_valid;
    assign ddc_i[c]  = ddc_bus[c].out_i;
    assign ddc_q[c]  = ddc_bus[c].out_q;

    addc_ddc u_ddc (
      .aclk    (aclk),
      .aresetn (aresetn),
      .bus     (ddc_bus[c])
    );
  end

  // ****************************************
  // Register bus, timing inputs and DMA
  // ****************************************
  always_comb begin
    logic [31:0] rd;
    logic        g_rise, g_fall, t_rise;
    logic        beat;
    logic [19:0] lw;
    rd = '0;
    beat = 1'b0;
    lw = '0;
    next_r = r;
    // Pins pass two flops; gate, trigger and sync add a third (gp, tp, sp) for edge detection.
    next_r.a1 = adc_a;
    next_r.a2 = r.a1;
    next_r.b1 = adc_b;
    next_r.b2 = r.b1;
    next_r.g1 = gate_in;
    next_r.g2 = r.g1;
    next_r.gp = r.g2;
    next_r.t1 = trig_in;
    next_r.t2 = r.t1;
    next_r.tp = r.t2;
    next_r.s1 = sync_in;
    next_r.s2 = r.s1;
    next_r.sp = r.s2;
    g_rise = r.g2 && !r.gp;
    g_fall = !r.g2;
    t_rise = r.t2 && !r.tp;
    next_r.test = r.test + 14'h0001;
    next_r.tstamp = (r.s2 && !r.sp) ? 32'h00000000 : r.tstamp + 32'h00000001;
    next_r.coef_we = '0;
    next_r.start = '0;
    next_r.run_q = r.ctrl[CTRL_RUN_LSB +: 2];

    if (s_axi_awvalid && r.awready) begin
      next_r.aw_have = 1'b1;
      next_r.awaddr_q = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.wready) begin
      next_r.w_have = 1'b1;
      next_r.wdata_q = s_axi_wdata;
      next_r.wstrb_q = s_axi_wstrb;
    end
    if (r.aw_have && r.w_have && !r.bvalid) begin
      next_r.aw_have = 1'b0;
      next_r.w_have = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = addc_mapped(r.awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      if (r.awaddr_q[7:5] == ADDC_LINK_BASE[7:5]) begin
        next_r.links[r.awaddr_q[4]][r.awaddr_q[3:2]] =
          20'(addc_merge(32'(r.links[r.awaddr_q[4]][r.awaddr_q[3:2]]), r.wdata_q, r.wstrb_q));
      end
      unique case (r.awaddr_q)
        ADDC_CTRL:      next_r.ctrl = addc_merge(r.ctrl, r.wdata_q, r.wstrb_q) & 32'h0000033F;
        ADDC_TUNE0:     next_r.tune[0] = addc_merge(r.tune[0], r.wdata_q, r.wstrb_q);
        ADDC_TUNE1:     next_r.tune[1] = addc_merge(r.tune[1], r.wdata_q, r.wstrb_q);
        ADDC_DECIM0:    next_r.decim[0] = 17'(addc_merge(32'(r.decim[0]), r.wdata_q, r.wstrb_q));
        ADDC_DECIM1:    next_r.decim[1] = 17'(addc_merge(32'(r.decim[1]), r.wdata_q, r.wstrb_q));
        ADDC_COEF_SEL:  next_r.coef_sel = r.wdata_q[4:0];
        ADDC_COEF_DATA: begin
          next_r.coef_data = r.wdata_q[15:0];
          next_r.coef_we[r.coef_sel[4]] = 1'b1;
          next_r.coef_sel[3:0] = r.coef_sel[3:0] + 4'h1;
        end
        default: begin
        end
      endcase
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end

    if (s_axi_arvalid && r.arready) begin
      unique case (s_axi_araddr)
        ADDC_CTRL:      rd = r.ctrl;
        ADDC_STATUS:    rd = {22'h0, r.ch[1].link, r.ch[1].state, r.ch[0].link, r.ch[0].state};
        ADDC_TUNE0:     rd = r.tune[0];
        ADDC_TUNE1:     rd = r.tune[1];
        ADDC_DECIM0:    rd = 32'(r.decim[0]);
        ADDC_DECIM1:    rd = 32'(r.decim[1]);
        ADDC_COEF_SEL:  rd = 32'(r.coef_sel);
        ADDC_TSTAMP:    rd = r.tstamp;
        default:        rd = (s_axi_araddr[7:5] == ADDC_LINK_BASE[7:5]) ?
                             32'(r.links[s_axi_araddr[4]][s_axi_araddr[3:2]]) : 32'h00000000;
      endcase
      next_r.rdata = rd;
      next_r.rresp = addc_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      next_r.rvalid = 1'b1;
    end
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end

    for (int c = 0; c < 2; c++) begin
      next_r.ch[c].ov = 1'b0;
      next_r.ch[c].om = 1'b0;
      lw = r.links[c][r.ch[c].link];
      unique case (r.ch[c].state)
        DMA_IDLE: begin
          if (r.ctrl[CTRL_RUN_LSB + c] && !r.run_q[c]) begin
            next_r.start[c] = 1'b1;
            next_r.ch[c].link = '0;
            next_r.ch[c].state = DMA_LOAD;
          end
        end
        DMA_LOAD: begin
          next_r.ch[c].len = lw[15:0];
          next_r.ch[c].gate = lw[LINK_GATE_BIT];
          next_r.ch[c].last = lw[LINK_LAST_BIT];
          next_r.ch[c].nxt = lw[LINK_NEXT_LSB +: 2];
          next_r.ch[c].cnt = '0;
          next_r.ch[c].state = DMA_WAIT;
        end
        DMA_WAIT: begin
          if (r.ch[c].gate ? g_rise : t_rise) begin
            next_r.ch[c].ts = r.tstamp;
            next_r.ch[c].state = (r.ch[c].gate || r.ch[c].len != 16'h0000) ?
                                 DMA_XFER : DMA_META;
          end
        end
        DMA_XFER: begin
          beat = ddc_ov[c] && (!r.ch[c].gate || r.g2);
          if (beat) begin
            next_r.ch[c].ov = 1'b1;
            next_r.ch[c].od = ddc_bus_pack(r.ctrl[CTRL_FMT_LSB + c], ddc_i[c], ddc_q[c]);
            next_r.ch[c].cnt = r.ch[c].cnt + 24'h000001;
          end
          if (r.ch[c].gate ? g_fall : (beat && 24'(r.ch[c].len) == r.ch[c].cnt + 24'h1)) begin
            next_r.ch[c].state = DMA_META;
          end
        end
        DMA_META: begin
          if (r.ctrl[CTRL_META_LSB + c]) begin
            next_r.ch[c].om = 1'b1;
            next_r.ch[c].od = {8'(c), r.ch[c].cnt, r.ch[c].ts};
          end
          next_r.ch[c].state = DMA_NEXT;
        end
        DMA_NEXT: begin
          next_r.ch[c].link = r.ch[c].nxt;
          next_r.ch[c].state = r.ch[c].last ? DMA_IDLE : DMA_LOAD;
        end
        default: next_r.ch[c].state = DMA_IDLE;
      endcase
      // Clearing run abandons the list at once; no metadata closes a cut transfer.
      if (!r.ctrl[CTRL_RUN_LSB + c]) begin
        next_r.ch[c].state = DMA_IDLE;
      end
      next_r.ch[c].ov = next_r.ch[c].ov | next_r.ch[c].om;
    end

    next_r.awready = !next_r.aw_have && !next_r.bvalid;
    next_r.wready = !next_r.w_have && !next_r.bvalid;
    next_r.arready = !next_r.rvalid;
    if (!aresetn) begin
      next_r = '0;
      next_r.decim = {DECIM_RST, DECIM_RST};
    end
  end

  function automatic logic [63:0] ddc_bus_pack(input logic f16, input logic [23:0] i,
                                               input logic [23:0] q);
    if (f16) begin
      return {32'h00000000, i[15:0], q[15:0]};
    end
    return {{8{i[23]}}, i, {8{q[23]}}, q};
  endfunction

  always_ff @(posedge aclk) begin
    r <= next_r;
  end

  assign s_axi_awready = r.awready;
  assign s_axi_wready  = r.wready;
  assign s_axi_bvalid  = r.bvalid;
  assign s_axi_bresp   = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid  = r.rvalid;
  assign s_axi_rdata   = r.rdata;
  assign s_axi_rresp   = r.rresp;
  assign dma_valid     = {r.ch[1].ov, r.ch[0].ov};
  assign dma_meta      = {r.ch[1].om, r.ch[0].om};
  assign dma_data      = {r.ch[1].od, r.ch[0].od};

  // ****************************************
  // Checks
  // ****************************************
  chk_src_route: assert property (@(posedge aclk) disable iff (!aresetn)
    r.ctrl[5:4] == SRC_ADC_A && $past(aresetn) && $past(aresetn, 2)
    |-> ddc_bus[0].sample == $past(adc_a, 2))
    else $error("channel zero not fed from selected converter");
  chk_data_in_xfer: assert property (@(posedge aclk) disable iff (!aresetn)
    r.ch[0].ov && !r.ch[0].om |-> $past(r.ch[0].state) == DMA_XFER && $past(ddc_ov[0]))
    else $error("data beat outside a transfer");
  chk_fixed_len: assert property (@(posedge aclk) disable iff (!aresetn)
    r.ch[0].state == DMA_XFER && !r.ch[0].gate |-> r.ch[0].cnt < 24'(r.ch[0].len))
    else $error("fixed transfer ran past its length");
  chk_gate_end: assert property (@(posedge aclk) disable iff (!aresetn)
    r.ch[0].state == DMA_XFER && r.ch[0].gate && !r.g2 && r.ctrl[0]
    |=> r.ch[0].state == DMA_META ##1 r.ch[0].state == DMA_NEXT)
    else $error("gated transfer outlived its gate");
  chk_meta_len: assert property (@(posedge aclk) disable iff (!aresetn)
    r.ch[1].om |-> r.ch[1].od[63:32] == {8'h01, $past(r.ch[1].cnt)} && r.ch[1].ov)
    else $error("metadata beat carries wrong id or length");

  cov_gate_xfer: cover property (@(posedge aclk) disable iff (!aresetn)
    r.ch[0].state == DMA_XFER && r.ch[0].gate ##[1:1000] r.ch[0].om);
  cov_shared_src: cover property (@(posedge aclk) disable iff (!aresetn)
    r.ctrl[5:4] == r.ctrl[7:6] && ddc_ov[0] && ddc_ov[1]);
  cov_list_walk: cover property (@(posedge aclk) disable iff (!aresetn)
    r.ch[1].state == DMA_NEXT && !r.ch[1].last);
  cov_axi_err: cover property (@(posedge aclk) disable iff (!aresetn)
    r.bvalid && r.bresp == RESP_SLVERR);

endmodule

// *** testbench/addc_adc_model.sv ***
// Converter model: a stepping ramp on one input, noise on the other.
`timescale 1ns/1ns
module addc_adc_model (
  input  wire logic   aclk,
  output logic [13:0] adc_a,
  output logic [13:0] adc_b
);
  initial {adc_a, adc_b} = '0;
  always @(posedge aclk) begin
    adc_a <= adc_a + 14'h0011;
    adc_b <= 14'($urandom);
  end
endmodule

// *** testbench/testbench.sv ***
// Bench: register access, fixed and gated transfers, output format.
`timescale 1ns/1ns
module testbench
  import addc_pkg::*;
;
  logic             aclk = 1'b0, aresetn, gate_in, trig_in, sync_in;
  logic [13:0]      adc_a, adc_b;
  logic [7:0]       s_axi_awaddr, s_axi_araddr;
  logic [31:0]      s_axi_wdata, s_axi_rdata, t, note, exp_q[2][$];
  logic             s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic             s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]       s_axi_bresp, s_axi_rresp, dma_valid, dma_meta;
  logic [1:0][63:0] dma_data;
  logic [63:0]      d;
  int               num_errors = 0, compares = 0, cnt[2] = '{0, 0}, n;
  addc_adc_model model (.aclk, .adc_a, .adc_b);
  addc_top dut (.aclk, .aresetn, .adc_a, .adc_b, .gate_in, .trig_in, .sync_in, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dma_valid,
    .dma_meta, .dma_data);
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic results();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Ready stays high after a handshake so no signal is driven twice in one time step.
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    int k;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    for (k = 0; k < 200; k++) begin
      @(posedge aclk);
      if (s_axi_bvalid === 1'b1) break;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    chk("bresp", 32'(er), (k < 200) ? 32'(s_axi_bresp) : 32'hFFFF_FFFF);
    if (k == 200) results();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int k;
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    for (k = 0; k < 200; k++) begin
      @(posedge aclk);
      if (s_axi_rvalid === 1'b1) break;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    chk("rdata", e, (k < 200) ? s_axi_rdata : ~e);
    chk("rresp", 32'(er), 32'(s_axi_rresp));
    if (k == 200) results();
  endtask
  always @(posedge aclk) begin
    for (int c = 0; c < 2; c++) begin
      d = dma_data[c];
      if (dma_valid[c] === 1'b1 && dma_meta[c] === 1'b1) begin
        note = (exp_q[c].size() > 0) ? exp_q[c].pop_front() : 32'hFFFF_FFFF;
        if (note[23:0] == 24'hFF_FFFF) note[23:0] = cnt[c][23:0];
        chk("meta", note, d[63:32]);
        cnt[c] = 0;
      end else if (dma_valid[c] === 1'b1) begin
        cnt[c]++;
        if (c == 1) chk("fmt16", 32'h0, d[63:32]);
        else chk("sext", {16'h0, {8{d[55]}}, {8{d[23]}}}, {16'h0, d[63:56], d[31:24]});
      end
    end
  end
  initial forever #4 aclk = ~aclk;
  initial begin
    {aresetn, gate_in, trig_in, sync_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    t = $urandom(46);
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    sync_in <= 1'b1;
    @(posedge aclk);
    rd(ADDC_DECIM1, 32'h2, RESP_OKAY);
    rd(8'h44, 32'h0, RESP_SLVERR);
    wr(8'h44, 32'h1, RESP_SLVERR);
    wr(ADDC_TUNE0, t, RESP_OKAY);
    rd(ADDC_TUNE0, t, RESP_OKAY);
    wr(ADDC_DECIM0, 32'h4, RESP_OKAY);
    wr(ADDC_COEF_DATA, {16'h0, t[15:0]}, RESP_OKAY);
    wr(ADDC_LINK_BASE, 32'h0002_0002, RESP_OKAY);
    wr(ADDC_LINK_BASE + 8'h10, 32'h0003_0000, RESP_OKAY);
    t = 32'h20F | (($urandom % 3) << 6);
    exp_q[0].push_back(32'h0000_0002);
    exp_q[1].push_back(32'h01FF_FFFF);
    wr(ADDC_CTRL, t, RESP_OKAY);
    rd(ADDC_CTRL, t, RESP_OKAY);
    {trig_in, gate_in} <= 2'b11;
    repeat (40) @(posedge aclk);
    gate_in <= 1'b0;
    for (n = 0; n < 500 && exp_q[0].size() + exp_q[1].size() > 0; n++) @(posedge aclk);
    chk("pending", 32'h0, 32'(exp_q[0].size() + exp_q[1].size()));
    results();
  end
endmodule
